// *** dv/cpu_read_model.sv ***
// Processor-side read master model for the flash controller
`timescale 1ns/1ps
module cpu_read_model (
    // Clock
    input wire logic mclk,
    // Read port
    output logic rd_req,
    output logic rd_is_fetch,
    output logic [13:0] rd_addr,
    input wire logic rd_ready,
    input wire logic [31:0] rd_data,
    input wire logic rd_bus_fault
);
    initial rd_req = 1'b0;
    initial rd_is_fetch = 1'b0;
    initial rd_addr = 14'h0000;
    // Request holds while the controller stalls it
    task automatic read(input logic [13:0] a, input logic f, output logic [31:0] d,
                        output logic flt);
        @(posedge mclk);
        rd_req <= 1'b1;
        rd_is_fetch <= f;
        rd_addr <= a;
        do @(negedge mclk); while (rd_ready !== 1'b1);
        @(posedge mclk);
        rd_req <= 1'b0;
        // Released address shows the inverse so a stale value is never trusted
        rd_addr <= ~a;
        @(negedge mclk);
        d = rd_data;
        flt = rd_bus_fault;
    endtask
endmodule

// *** dv/flash_ctrl_sva.sv ***
// Assertion checker on the flash controller's top ports
`timescale 1ns/1ps
module flash_ctrl_sva (
    // Clock, resets, run enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic clk_en,
    // Read port
    input wire logic rd_req,
    input wire logic rd_is_fetch,
    input wire logic [13:0] rd_addr,
    input wire logic rd_ready,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_bus_fault,
    // Command and protection
    input wire logic cmd_wr,
    input wire logic [31:0] cmd_wdata,
    input wire logic [13:0] cmd_addr,
    input wire logic [3:0] flash_command_reg,
    input wire logic busy,
    input wire logic [31:0] region_program_enable_bits,
    input wire logic [31:0] region_read_enable_bits,
    // Events
    input wire logic [1:0] flash_irq_mask,
    input wire logic [1:0] flash_raw_irq_status,
    input wire logic [1:0] flash_masked_irq_status,
    input wire logic flash_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire logic take_rd = clk_en && rd_req && rd_ready;
    wire logic take_cmd = clk_en && cmd_wr && !busy && cmd_wdata[31:16] == 16'hA442;
    wire logic pe_hit = region_program_enable_bits[cmd_addr[13:9]];
    wire logic wr_or_er = cmd_wdata[3:0] == 4'h1 || cmd_wdata[3:0] == 4'h2;
    AST_MASK: assert property (flash_masked_irq_status == (flash_raw_irq_status & flash_irq_mask))
        else $error("masked status is not raw and mask");
    AST_IRQ: assert property (flash_irq == |flash_masked_irq_status)
        else $error("interrupt line disagrees with masked status");
    AST_RD_ANS: assert property (take_rd |=> rd_valid)
        else $error("read not answered next cycle");
    AST_RD_FAULT: assert property (take_rd && !rd_is_fetch && !region_read_enable_bits[rd_addr[13:9]]
        |=> rd_bus_fault && rd_data == 32'h0000_0000) else $error("protected read not faulted");
    AST_FETCH_OK: assert property (take_rd && rd_is_fetch |=> !rd_bus_fault)
        else $error("instruction fetch faulted");
    AST_STALL: assert property (busy |-> !rd_ready)
        else $error("read accepted during operation");
    AST_REFUSE: assert property (take_cmd && wr_or_er && !pe_hit
        |=> !busy && flash_raw_irq_status[0]) else $error("protected change not refused");
    AST_ACCEPT: assert property (take_cmd && (cmd_wdata[3:0] == 4'h8 || cmd_wdata[3:0] == 4'h1 && pe_hit)
        |=> busy && flash_command_reg == $past(cmd_wdata[3:0])) else $error("command not started");
    AST_DONE: assert property ($fell(busy) && $past(flash_command_reg) != 4'h8
        |-> flash_raw_irq_status[1]) else $error("completion event missing");
    AST_CLR_ONLY: assert property (disable iff (!por_b)
        (region_program_enable_bits & ~$past(region_program_enable_bits)) == 32'h0000_0000)
        else $error("program enable bit went back to one");
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the flash protection and timing controller
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, rst_b = 1'b0, por_b = 1'b0, clk_en = 1'b1;
    logic rd_req, rd_is_fetch, rd_ready, rd_valid, rd_bus_fault, busy, flash_irq;
    logic [13:0] rd_addr, cmd_addr = 14'h0000;
    logic [31:0] rd_data, cmd_wdata = 32'h0000_0000, cmd_data = 32'h0000_0000;
    logic cmd_wr = 1'b0, prog_en_clr_wr = 1'b0, read_en_clr_wr = 1'b0, usec_wr = 1'b0;
    logic clr_wr = 1'b0;
    logic [31:0] prog_en_clr_mask = 32'h0000_0000, read_en_clr_mask = 32'h0000_0000;
    logic [31:0] region_program_enable_bits, region_read_enable_bits;
    logic [31:0] committed_program_bits, committed_read_bits;
    logic [7:0] usec_wdata = 8'h00, microsecond_reload;
    logic [3:0] flash_command_reg;
    logic [1:0] flash_irq_mask = 2'b00, flash_masked_irq_clear = 2'b00;
    logic [1:0] flash_raw_irq_status, flash_masked_irq_status;
    int failures = 0, checks_done = 0, n;
    logic [31:0] d, pm;
    logic f;
    typedef struct packed {logic [4:0] rg; logic pe; logic re; logic flt; logic rfs;} row_t;
    row_t rows [4] = '{'{5'h01, 1'b0, 1'b0, 1'b1, 1'b1}, '{5'h02, 1'b1, 1'b0, 1'b1, 1'b0},
                       '{5'h03, 1'b0, 1'b1, 1'b0, 1'b1}, '{5'h04, 1'b1, 1'b1, 1'b0, 1'b0}};
    flash_protect_and_timing_ctrl uut (.mclk, .rst_b, .por_b, .clk_en, .rd_req, .rd_is_fetch,
        .rd_addr, .rd_ready, .rd_data, .rd_valid, .rd_bus_fault, .cmd_wr, .cmd_wdata, .cmd_addr,
        .cmd_data, .flash_command_reg, .busy, .prog_en_clr_wr, .prog_en_clr_mask, .read_en_clr_wr,
        .read_en_clr_mask, .region_program_enable_bits, .region_read_enable_bits,
        .committed_program_bits, .committed_read_bits, .usec_wr, .usec_wdata,
        .microsecond_reload, .flash_irq_mask, .clr_wr, .flash_masked_irq_clear,
        .flash_raw_irq_status, .flash_masked_irq_status, .flash_irq);
    cpu_read_model host (.mclk, .rd_req, .rd_is_fetch, .rd_addr, .rd_ready, .rd_data,
        .rd_bus_fault);
    always #20 mclk = ~mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Counts: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Returns the number of cycles busy stood; zero means the command was refused
    task automatic cmd(input logic [31:0] w, input logic [13:0] a, input logic [31:0] v);
        @(posedge mclk);
        cmd_wr <= 1'b1;
        cmd_wdata <= w;
        cmd_addr <= a;
        cmd_data <= v;
        @(posedge mclk);
        cmd_wr <= 1'b0;
        n = 0;
        @(negedge mclk);
        while (busy === 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        if (busy === 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic clr(input logic [1:0] m);
        @(posedge mclk);
        clr_wr <= 1'b1;
        flash_masked_irq_clear <= m;
        @(posedge mclk);
        clr_wr <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic pulse_rst(input logic por);
        @(posedge mclk);
        rst_b <= 1'b0;
        por_b <= ~por;
        @(posedge mclk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(negedge mclk);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(negedge mclk);
        check(32'(microsecond_reload), 32'h18);
        check(region_program_enable_bits & region_read_enable_bits, 32'hFFFF_FFFF);
        @(posedge mclk);
        usec_wr <= 1'b1;
        usec_wdata <= 8'h01;
        @(posedge mclk);
        usec_wr <= 1'b0;
        // The old reload still paces the count until its next zero; let it pass
        repeat (30) @(posedge mclk);
        cmd(32'hA442_0002, 14'h0000, 32'h0);
        // Two cycles a microsecond, twenty microseconds, plus partial tick and one cycle
        check(32'(n >= 40 && n <= 44), 32'h1);
        check(32'(flash_raw_irq_status), 32'h2);
        host.read(14'h00FF, 1'b0, d, f);
        check(d, 32'hFFFF_FFFF);
        cmd(32'hA442_0001, 14'h0000, 32'h1234_5678);
        cmd(32'hA442_0001, 14'h0000, 32'hFFFF_00FF);
        host.read(14'h0000, 1'b0, d, f);
        check(d, 32'h1234_0078);
        cmd(32'h0000_0001, 14'h0000, 32'h0);
        check(32'(n), 32'h0);
        fork
            cmd(32'hA442_0001, 14'h0001, 32'h0);
            begin
                repeat (3) @(posedge mclk);
                host.read(14'h0001, 1'b0, d, f);
                check(32'(busy), 32'h0);
                check(d, 32'h0);
            end
        join
        $display("Timing, erase, program and stall tests done");
        @(posedge mclk);
        flash_irq_mask <= 2'b10;
        @(negedge mclk);
        check(32'({flash_masked_irq_status, flash_irq}), 32'h5);
        clr(2'b00);
        check(32'(flash_raw_irq_status), 32'h2);
        clr(2'b10);
        check(32'(flash_raw_irq_status), 32'h0);
        // A write while the enable is low must not land
        @(posedge mclk);
        {clk_en, usec_wr, usec_wdata} <= {2'b01, 8'h07};
        @(posedge mclk);
        {clk_en, usec_wr} <= 2'b10;
        @(negedge mclk);
        check(32'(microsecond_reload), 32'h01);
        $display("Event status tests done");
        pm = 32'h0;
        foreach (rows[i]) pm[rows[i].rg] = ~rows[i].pe;
        d = 32'h0;
        foreach (rows[i]) d[rows[i].rg] = ~rows[i].re;
        @(posedge mclk);
        {prog_en_clr_wr, read_en_clr_wr, prog_en_clr_mask, read_en_clr_mask} <= {2'b11, pm, d};
        flash_irq_mask <= 2'b01;
        @(posedge mclk);
        {prog_en_clr_wr, read_en_clr_wr} <= 2'b00;
        foreach (rows[i]) begin
            host.read({rows[i].rg, 9'h000}, 1'b0, d, f);
            check(32'(f), 32'(rows[i].flt));
            host.read({rows[i].rg, 9'h000}, 1'b1, d, f);
            check(32'(f), 32'h0);
            cmd(32'hA442_0001, {rows[i].rg, 9'h000}, 32'h0);
            check(32'(n == 0), 32'(rows[i].rfs));
            check(32'({flash_raw_irq_status[0], flash_irq}), 32'({2{rows[i].rfs}}));
            clr(2'b11);
        end
        cmd(32'hA442_0002, 14'h0200, 32'h0);
        check(32'(n), 32'h0);
        cmd(32'hA442_0004, 14'h0000, 32'h0);
        host.read(14'h0400, 1'b1, d, f);
        check(d, 32'hFFFF_FFFF);
        $display("Protection policy tests done");
        pulse_rst(1'b0);
        check(region_program_enable_bits, ~pm);
        check(32'(microsecond_reload), 32'h18);
        pulse_rst(1'b1);
        check(region_program_enable_bits & region_read_enable_bits, 32'hFFFF_FFFF);
        @(posedge mclk);
        read_en_clr_wr <= 1'b1;
        read_en_clr_mask <= 32'h0000_0020;
        @(posedge mclk);
        read_en_clr_wr <= 1'b0;
        cmd(32'hA442_0008, 14'h0000, 32'h0);
        pulse_rst(1'b1);
        check(committed_read_bits & region_read_enable_bits, 32'hFFFF_FFDF);
        @(negedge mclk);
        check(region_read_enable_bits, 32'hFFFF_FFDF);
        check(committed_program_bits, 32'hFFFF_FFFF);
        $display("Reset and commit tests done");
        wrap_up();
    end
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
endmodule
bind flash_protect_and_timing_ctrl flash_ctrl_sva chk (.mclk, .rst_b, .por_b, .clk_en, .rd_req,
    .rd_is_fetch, .rd_addr, .rd_ready, .rd_data, .rd_valid, .rd_bus_fault, .cmd_wr, .cmd_wdata,
    .cmd_addr, .flash_command_reg, .busy, .region_program_enable_bits, .region_read_enable_bits,
    .flash_irq_mask, .flash_raw_irq_status, .flash_masked_irq_status, .flash_irq);

// *** rtl/flash_ctrl_pkg.sv ***
// Package: constants and types for the flash protection and timing controller
package flash_ctrl_pkg;
    localparam int WORD_W = 32;
    localparam int BLOCK_WORDS = 256;
    localparam int NUM_BLOCKS = 64;
    localparam int NUM_REGIONS = 32;
    localparam int ADDR_W = 14;
    localparam int BLOCK_LSB = 8;
    localparam int REGION_LSB = 9;
    localparam int USEC_W = 8;
    // Clock is 25 MHz; the part's maximum rate sets the reload default
    localparam int MAX_CLK_MHZ = 25;
    localparam logic [7:0] USEC_RELOAD_RESET = 8'(MAX_CLK_MHZ - 1);
    // Program, erase and commit durations in microseconds
    localparam int PROG_TIME_US = 20;
    localparam int ERASE_TIME_US = 20;
    localparam int COMMIT_TIME_US = 20;
    localparam int OP_CNT_W = 16;
    localparam logic [15:0] PROG_US = 16'(PROG_TIME_US);
    localparam logic [15:0] ERASE_US = 16'(ERASE_TIME_US);
    localparam logic [15:0] COMMIT_US = 16'(COMMIT_TIME_US);
    localparam logic [31:0] PROT_FACTORY = 32'hFFFF_FFFF;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam logic [15:0] CMD_KEY = 16'hA442;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_MERASE_BIT = 2;
    localparam int CMD_COMMIT_BIT = 3;
    localparam int IRQ_ACCESS_BIT = 0;
    localparam int IRQ_PROG_BIT = 1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PROG = 3'b001,
        ST_ERASE = 3'b010,
        ST_MERASE = 3'b011,
        ST_COMMIT = 3'b100
    } op_state_t;
endpackage

// *** rtl/flash_protect_and_timing_ctrl.sv ***
// Flash controller: region protection, program/erase timing, event status
// How it works
// R1 - Erase sets whole 1-KB block to ones
// R2 - Programming only clears bits, never sets
// R3 - Each 2-KB region has program and read bits
// R4 - Program bit zero refuses program and erase
// R5 - Read bit zero allows only instruction fetch
// R6 - Bit pairs select execute, write, read-only, full
// R7 - Protected data read blocked with bus fault
// R8 - Refused program records access event, masked interrupt
// R9 - Protection bits come up as ones
// R10 - Bits only clear; uncommitted restored by power-on
// R11 - Commit makes cleared bits permanent
// R12 - Finished program or erase records completion event
// R13 - Raw status visible; masked is raw AND mask
// R14 - Writing one clears event; zero does nothing
// R15 - Reload resets to maximum-clock timing value
// R16 - Software loads reload with MHz minus one
// R17 - Timing counts cycles per microsecond from reload
// R18 - Flash accesses stall during program or erase
// R19 - Keyed commit command; bit holds until done
// R20 - Timebase reloads, ticks at zero, paces delays
`timescale 1ns/1ps
module flash_protect_and_timing_ctrl (
    // Clock and resets
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic clk_en,
    // Processor read port
    input wire logic rd_req,
    input wire logic rd_is_fetch,
    input wire logic [13:0] rd_addr,
    output logic rd_ready,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic rd_bus_fault,
    // Flash command
    input wire logic cmd_wr,
    input wire logic [31:0] cmd_wdata,
    input wire logic [13:0] cmd_addr,
    input wire logic [31:0] cmd_data,
    output logic [3:0] flash_command_reg,
    output logic busy,
    // Protection
    input wire logic prog_en_clr_wr,
    input wire logic [31:0] prog_en_clr_mask,
    input wire logic read_en_clr_wr,
    input wire logic [31:0] read_en_clr_mask,
    output logic [31:0] region_program_enable_bits,
    output logic [31:0] region_read_enable_bits,
    output logic [31:0] committed_program_bits,
    output logic [31:0] committed_read_bits,
    // Timing
    input wire logic usec_wr,
    input wire logic [7:0] usec_wdata,
    output logic [7:0] microsecond_reload,
    // Events
    input wire logic [1:0] flash_irq_mask,
    input wire logic clr_wr,
    input wire logic [1:0] flash_masked_irq_clear,
    output logic [1:0] flash_raw_irq_status,
    output logic [1:0] flash_masked_irq_status,
    output logic flash_irq
);
    logic [31:0] mem [0:16383];
    // Nonvolatile copies start in the factory state; no reset ever reaches them
    logic [31:0] pe_nv_reg = flash_ctrl_pkg::PROT_FACTORY; // [R9]
    logic [31:0] re_nv_reg = flash_ctrl_pkg::PROT_FACTORY; // [R9]
    logic [31:0] pe_reg;
    logic [31:0] re_reg;
    logic [7:0] usec_reg;
    flash_ctrl_pkg::op_state_t state_reg;
    logic [15:0] us_left_reg;
    logic [13:0] op_addr_reg;
    logic [31:0] op_data_reg;
    logic [8:0] erase_idx_reg;
    logic [14:0] merase_idx_reg;
    logic [3:0] cmd_bits_reg;
    logic [1:0] raw_reg;
    logic [31:0] rd_data_reg;
    logic rd_valid_reg;
    logic rd_fault_reg;
    logic access_hit;
    logic done_pulse;
    logic key_ok;
    logic [4:0] cmd_region;
    usec_tick_if tb_if ();

    usec_timebase u_timebase (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .tb(tb_if.gen)
    );

    assign tb_if.reload = usec_reg;
    assign key_ok = cmd_wr && (cmd_wdata[31:16] == flash_ctrl_pkg::CMD_KEY)
        && (state_reg == flash_ctrl_pkg::ST_IDLE);
    assign cmd_region = cmd_addr[13:9];

    // Reload defaults to maximum-clock timing; software retunes it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            usec_reg <= flash_ctrl_pkg::USEC_RELOAD_RESET; // [R15]
        end else if (clk_en && usec_wr) begin
            usec_reg <= usec_wdata; // [R16]
        end
    end

    // Committed bits must outlive power-on reset, so only a finished commit writes them
    always_ff @(posedge mclk) begin
        if (clk_en && state_reg == flash_ctrl_pkg::ST_COMMIT
            && us_left_reg == 16'h0000) begin
            pe_nv_reg <= pe_nv_reg & pe_reg; // [R11]
            re_nv_reg <= re_nv_reg & re_reg;
        end
    end

    // Working bits survive system reset; power-on loads ones, then committed values apply again next cycle
    always_ff @(posedge mclk or negedge por_b) begin
        if (!por_b) begin
            pe_reg <= flash_ctrl_pkg::PROT_FACTORY; // [R9] [R10]
            re_reg <= flash_ctrl_pkg::PROT_FACTORY;
        end else if (clk_en) begin
            pe_reg <= pe_reg & pe_nv_reg & ~(prog_en_clr_wr ? prog_en_clr_mask : 32'h0000_0000); // [R10]
            re_reg <= re_reg & re_nv_reg & ~(read_en_clr_wr ? read_en_clr_mask : 32'h0000_0000);
        end
    end

    // Protected program or erase attempt
    assign access_hit = key_ok && !pe_reg[cmd_region]
        && (cmd_wdata[flash_ctrl_pkg::CMD_WRITE_BIT]
        || cmd_wdata[flash_ctrl_pkg::CMD_ERASE_BIT]); // [R4] [R8]

    // Operation sequencer paced by microsecond ticks
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= flash_ctrl_pkg::ST_IDLE;
            us_left_reg <= 16'h0000;
            op_addr_reg <= 14'h0000;
            op_data_reg <= 32'h0000_0000;
            cmd_bits_reg <= 4'h0;
        end else if (clk_en) begin
            case (state_reg)
                flash_ctrl_pkg::ST_IDLE: begin
                    if (key_ok && !access_hit) begin
                        op_addr_reg <= cmd_addr;
                        op_data_reg <= cmd_data;
                        if (cmd_wdata[flash_ctrl_pkg::CMD_WRITE_BIT]) begin
                            state_reg <= flash_ctrl_pkg::ST_PROG;
                            us_left_reg <= flash_ctrl_pkg::PROG_US;
                            cmd_bits_reg <= 4'h1;
                        end else if (cmd_wdata[flash_ctrl_pkg::CMD_ERASE_BIT]) begin
                            state_reg <= flash_ctrl_pkg::ST_ERASE;
                            us_left_reg <= flash_ctrl_pkg::ERASE_US;
                            cmd_bits_reg <= 4'h2;
                        end else if (cmd_wdata[flash_ctrl_pkg::CMD_MERASE_BIT]) begin
                            // Mass erase only clears regions whose program bit is set
                            state_reg <= flash_ctrl_pkg::ST_MERASE;
                            us_left_reg <= flash_ctrl_pkg::ERASE_US;
                            cmd_bits_reg <= 4'h4;
                        end else if (cmd_wdata[flash_ctrl_pkg::CMD_COMMIT_BIT]) begin
                            state_reg <= flash_ctrl_pkg::ST_COMMIT; // [R19]
                            us_left_reg <= flash_ctrl_pkg::COMMIT_US;
                            cmd_bits_reg <= 4'h8;
                        end
                    end
                end
                flash_ctrl_pkg::ST_PROG, flash_ctrl_pkg::ST_ERASE,
                flash_ctrl_pkg::ST_MERASE, flash_ctrl_pkg::ST_COMMIT: begin
                    if (us_left_reg == 16'h0000) begin
                        state_reg <= flash_ctrl_pkg::ST_IDLE;
                        cmd_bits_reg <= 4'h0; // [R19]
                    end else if (tb_if.tick) begin
                        us_left_reg <= us_left_reg - 16'h0001; // [R17] [R20]
                    end
                end
                default: begin
                    state_reg <= flash_ctrl_pkg::ST_IDLE;
                    cmd_bits_reg <= 4'h0;
                end
            endcase
        end
    end

    assign done_pulse = clk_en && (state_reg != flash_ctrl_pkg::ST_IDLE)
        && (state_reg != flash_ctrl_pkg::ST_COMMIT) && (us_left_reg == 16'h0000);

    // Array writes land at the end of the timed operation
    always_ff @(posedge mclk) begin
        if (done_pulse) begin
            case (state_reg)
                flash_ctrl_pkg::ST_PROG: begin
                    mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg; // [R2]
                end
                flash_ctrl_pkg::ST_ERASE: begin
                    for (int i = 0; i < flash_ctrl_pkg::BLOCK_WORDS; i++) begin
                        mem[{op_addr_reg[13:8], 8'(i)}] <= flash_ctrl_pkg::ERASED_WORD; // [R1]
                    end
                end
                flash_ctrl_pkg::ST_MERASE: begin
                    for (int i = 0; i < 16384; i++) begin
                        if (pe_reg[i / 512]) begin
                            mem[i] <= flash_ctrl_pkg::ERASED_WORD;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Event flags; a new event beats a same-cycle clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            raw_reg <= 2'b00;
        end else if (clk_en) begin
            raw_reg <= (raw_reg & ~(clr_wr ? flash_masked_irq_clear : 2'b00)) // [R14]
                | {done_pulse, access_hit}; // [R8] [R12]
        end
    end

    assign flash_raw_irq_status = raw_reg; // [R13]
    assign flash_masked_irq_status = raw_reg & flash_irq_mask; // [R13]
    assign flash_irq = |(raw_reg & flash_irq_mask); // [R8]

    // Reads stall while an operation runs; policy per region bit pair
    assign busy = (state_reg != flash_ctrl_pkg::ST_IDLE);
    assign rd_ready = !busy; // [R18]

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg <= 32'h0000_0000;
            rd_valid_reg <= 1'b0;
            rd_fault_reg <= 1'b0;
        end else if (clk_en) begin
            rd_valid_reg <= rd_req && !busy;
            rd_fault_reg <= rd_req && !busy && !rd_is_fetch && !re_reg[rd_addr[13:9]]; // [R5] [R6] [R7]
            if (rd_req && !busy) begin
                rd_data_reg <= (rd_is_fetch || re_reg[rd_addr[13:9]]) ? mem[rd_addr] : 32'h0000_0000; // [R3] [R7]
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_bus_fault = rd_fault_reg;
    assign flash_command_reg = cmd_bits_reg;
    assign region_program_enable_bits = pe_reg;
    assign region_read_enable_bits = re_reg;
    assign committed_program_bits = pe_nv_reg;
    assign committed_read_bits = re_nv_reg;
    assign microsecond_reload = usec_reg;
endmodule

// *** rtl/usec_tick_if.sv ***
// Interface: microsecond timebase link between controller and tick generator
`timescale 1ns/1ps
interface usec_tick_if;
    logic [7:0] reload;
    logic tick;
    modport ctrl (output reload, input tick);
    modport gen (input reload, output tick);
endinterface

// *** rtl/usec_timebase.sv ***
// Microsecond tick generator reloading from the cycles-per-microsecond value
`timescale 1ns/1ps
module usec_timebase (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Timebase link
    usec_tick_if.gen tb
);
    logic [7:0] count_reg;

    // A reload change takes effect at the next zero crossing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= flash_ctrl_pkg::USEC_RELOAD_RESET;
        end else if (clk_en) begin
            if (count_reg == 8'h00) begin
                count_reg <= tb.reload; // [R17] [R20]
            end else begin
                count_reg <= count_reg - 8'h01;
            end
        end
    end

    assign tb.tick = clk_en && (count_reg == 8'h00); // [R20]
endmodule
